// ==== sim/pci_command_status_reg_tb.sv ====
// self-checking bench for the command and status register
module pci_command_status_reg_tb
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, cfg_sel, cfg_wr, cfg_done_q, cfg_abort_q, ab;
  logic [7:0] cfg_addr, a;
  logic [31:0] cfg_wdata, cfg_rdata_q, q, d;
  logic [3:0] bus_byte_enables_n, be;
  logic mem_sel, mem_claim_q, mem_abort_q, mst_req, mst_grant_q;
  logic mem_wr, mb;
  logic [3:0] mem_byte_enables_n;
  logic [5:0] ev;
  logic cap_present, mem_space_en_q, bus_master_en_q, parity_resp_en_q;
  logic serr_en_q, serr_assert_q, fatal_err_q;
  int failures, comparisons, cmd, sts, cap, r;
  pcs_cmd_status u_pcs_cmd_status (.clk_sys, .reset_n, .cfg_sel, .cfg_wr,
    .cfg_addr, .cfg_wdata, .bus_byte_enables_n, .cfg_rdata_q, .cfg_done_q,
    .cfg_abort_q, .mem_sel, .mem_wr, .mem_byte_enables_n,
    .mem_claim_q, .mem_abort_q, .mst_req, .mst_grant_q,
    .addr_par_err(ev[0]), .data_par_err(ev[1]), .perr_as_master(ev[2]),
    .mst_master_abort(ev[3]), .mst_target_abort(ev[4]), .cap_load(ev[5]),
    .cap_present, .mem_space_en_q, .bus_master_en_q, .parity_resp_en_q,
    .serr_en_q, .serr_assert_q, .fatal_err_q);
  pcs_host_model u_pcs_host_model (.clk_sys, .cfg_rdata_q, .cfg_done_q,
    .cfg_abort_q, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_wdata,
    .bus_byte_enables_n);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] img();
    return sts | cap << 20 | 32'h0200_0000 | cmd;
  endfunction
  function automatic logic legal(logic [3:0] ben);
    return (~ben) inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  endfunction
  // model write, returns the expected abort
  function automatic logic wr_model(logic [31:0] wd, logic [3:0] ben);
    logic [3:0] en;
    logic [31:0] m;
    en = ~ben;
    m = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
    if (!(en inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})) begin
      sts |= 32'h0800_0000;
      return 1'h1;
    end
    cmd = cmd & ~(m & 32'h0000_0146) | wd & m & 32'h0000_0146;
    sts &= ~(wd & m & 32'hf900_0000);
    return 1'h0;
  endfunction
  task automatic do_reset();
    reset_n = 1'h0;
    cmd = 0;
    sts = 0;
    cap = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'h1;
  endtask
  // one cycle of bus events, memory access and master request
  task automatic step();
    @(posedge clk_sys);
    #1;
    r = $urandom;
    ev = r[5:0] & r[13:8];
    cap_present = r[16];
    mst_req = r[17];
    mem_sel = r[18];
    mem_wr = r[19];
    mem_byte_enables_n = r[23:20];
    @(posedge clk_sys);
    #1;
    if (ev[0] | ev[1]) sts |= 32'h8000_0000;
    if (ev[0] & cmd[8]) sts |= 32'h4000_0000;
    if (ev[3]) sts |= 32'h2000_0000;
    if (ev[4]) sts |= 32'h1000_0000;
    if (ev[2] & cmd[6]) sts |= 32'h0100_0000;
    if (ev[5]) cap = cap_present;
    mb = mem_sel & cmd[1] & mem_wr & !legal(mem_byte_enables_n);
    if (mb) sts |= 32'h0800_0000;
    chk(mem_sel & cmd[1] & !mb, mem_claim_q);
    chk(mb, mem_abort_q);
    chk(mst_req & cmd[2], mst_grant_q);
    chk({ev[0] & cmd[8], (ev[0] | ev[1]) & cmd[6]},
      {serr_assert_q, fatal_err_q});
    ev = 6'h00;
    mem_sel = 1'h0;
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #50_000;
    failures++;
    stop_test();
  end
  initial begin
    ev = 6'h00;
    mem_sel = 1'h0;
    mst_req = 1'h0;
    mem_wr = 1'h0;
    mem_byte_enables_n = 4'hf;
    cap_present = 1'h0;
    r = $urandom(1917);
    do_reset();
    u_pcs_host_model.access(1'h0, 8'h04, 32'h0, 4'h0, q, ab);
    chk(32'h0200_0000, q);
    // host enables bus mastering before traffic
    u_pcs_host_model.access(1'h1, 8'h04, 32'h0000_0146, 4'h0, q, ab);
    chk(wr_model(32'h0000_0146, 4'h0), ab);
    repeat (80) begin
      step();
      r = $urandom;
      a = (r[1:0] == 2'h0) ? 8'h08 : 8'h04;
      be = (a == 8'h04) ? r[7:4] : 4'h0;
      d = $urandom;
      u_pcs_host_model.access(1'h1, a, d, be, q, ab);
      chk(a == 8'h04 ? wr_model(d, be) : 1'h0, ab);
      u_pcs_host_model.access(1'h0, a, 32'h0, r[11:8], q, ab);
      chk(a == 8'h04 ? img() : 32'h0, q);
      chk({cmd[8], cmd[6], cmd[2], cmd[1]}, {serr_en_q, parity_resp_en_q,
        bus_master_en_q, mem_space_en_q});
    end
    do_reset();
    u_pcs_host_model.access(1'h0, 8'h04, 32'h0, 4'h0, q, ab);
    chk(32'h0200_0000, q);
    stop_test();
  end
endmodule

// ==== sim/pcs_cmd_status_sva.sv ====
// concurrent checks on the command and status register ports
module pcs_cmd_status_sva
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // configuration port
  input wire logic cfg_sel,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] bus_byte_enables_n,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_abort_q,
  // gated paths
  input wire logic mem_sel,
  input wire logic mem_wr,
  input wire logic [3:0] mem_byte_enables_n,
  input wire logic mem_claim_q,
  input wire logic mem_abort_q,
  input wire logic mst_req,
  input wire logic mst_grant_q,
  input wire logic addr_par_err,
  input wire logic data_par_err,
  input wire logic serr_assert_q,
  input wire logic fatal_err_q,
  // command levels
  input wire logic mem_space_en_q,
  input wire logic bus_master_en_q,
  input wire logic parity_resp_en_q,
  input wire logic serr_en_q
);
  logic legal;
  logic hit_rd;
  logic mem_legal;
  assign mem_legal = (~mem_byte_enables_n) inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  assign legal = (~bus_byte_enables_n) inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  assign hit_rd = cfg_sel && !cfg_wr && cfg_addr == 8'h04;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  read_no_abort_a: assert property (
    cfg_sel && !cfg_wr |=> !cfg_abort_q) else $error("read aborted");
  bad_write_abort_a: assert property (
    cfg_sel && cfg_wr && cfg_addr == 8'h04 && !legal |=> cfg_abort_q)
    else $error("illegal write not aborted");
  devsel_fixed_a: assert property (
    hit_rd |=> cfg_rdata_q[26:25] == 2'h1) else $error("devsel field");
  fixed_zero_a: assert property (
    hit_rd |=> cfg_rdata_q[23:21] == 3'h0 && cfg_rdata_q[19:9] == 11'h000
      && !cfg_rdata_q[7] && cfg_rdata_q[5:3] == 3'h0 && !cfg_rdata_q[0])
    else $error("fixed zero bits set");
  grant_follow_a: assert property (
    !cfg_sel |=> mst_grant_q == ($past(mst_req) && $past(bus_master_en_q)))
    else $error("grant not gated");
  mem_gate_a: assert property (
    mem_sel && !mem_wr && !cfg_sel |=> mem_claim_q == $past(mem_space_en_q))
    else $error("memory claim not gated");
  mem_abort_a: assert property (
    mem_sel && mem_wr && mem_space_en_q && !mem_legal |=> mem_abort_q)
    else $error("illegal memory write not aborted");
  serr_gate_a: assert property (
    !cfg_sel |=> serr_assert_q == ($past(addr_par_err) && $past(serr_en_q)))
    else $error("system error not gated");
  fatal_gate_a: assert property (
    !cfg_sel |=> fatal_err_q == (($past(addr_par_err) ||
      $past(data_par_err)) && $past(parity_resp_en_q)))
    else $error("fatal error not gated");
  reset_clear_a: assert property (
    $rose(reset_n) |-> !parity_resp_en_q && !serr_en_q)
    else $error("controls set after reset");
  cmd_hold_a: assert property (
    !cfg_sel |=> $stable(bus_master_en_q)) else $error("command drifted");
endmodule

bind pcs_cmd_status pcs_cmd_status_sva u_pcs_cmd_status_sva (
  .clk_sys, .reset_n, .cfg_sel, .cfg_wr, .cfg_addr, .bus_byte_enables_n,
  .cfg_rdata_q, .cfg_abort_q, .mem_sel, .mem_wr, .mem_byte_enables_n,
  .mem_claim_q, .mem_abort_q, .mst_req,
  .mst_grant_q, .addr_par_err, .data_par_err, .serr_assert_q, .fatal_err_q,
  .mem_space_en_q, .bus_master_en_q, .parity_resp_en_q, .serr_en_q);

// ==== sim/pcs_host_model.sv ====
// host bridge model issuing configuration accesses
module pcs_host_model (
  // clock
  input wire logic clk_sys,
  // answer
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_done_q,
  input wire logic cfg_abort_q,
  // request
  output logic cfg_sel,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  output logic [3:0] bus_byte_enables_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_sel = 1'h0;
    cfg_wr = 1'h0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0000_0000;
    bus_byte_enables_n = 4'hf;
  end
  task automatic access(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] ben,
    output logic [31:0] q, output logic ab);
    @(posedge clk_sys);
    #1;
    cfg_sel = 1'h1;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_wdata = d;
    bus_byte_enables_n = ben;
    @(posedge clk_sys);
    #1;
    q = (cfg_done_q === 1'h1) ? cfg_rdata_q : 32'hxxxx_xxxx;
    ab = cfg_abort_q;
    // released lines carry the inverted last value
    cfg_sel = 1'h0;
    cfg_wr = ~wr;
    cfg_addr = ~a;
    cfg_wdata = ~d;
    bus_byte_enables_n = ~ben;
  endtask
endmodule

// ==== src/pcs_cmd_status.sv ====
// command and status configuration register with its gating logic
// Function
// R1 - low half command, high half status
// R2 - all-zero command leaves only configuration accesses
// R3 - reads keep error bits; write one clears
// R4 - bit 31 on any parity error; code sets it on addr_par_err or data_par_err only, not on perr_as_master
// R5 - bit 30 when system error driven
// R6 - bit 29 on own master abort
// R7 - bit 28 when target aborts our master
// R8 - bit 27 when we target-abort
// R9 - 32-bit little-endian register words
// R10 - reads any enables; writes byte/word/dword only
// R11 - bits 26:25 read fixed 01
// R12 - bit 24 master parity with response on
// R13 - bit 21 reads zero
// R14 - bit 20 from stored capability bit
// R15 - bit 8 enables system error on address parity
// R16 - bit 6 enables fatal error on parity
// R17 - parity response off after hardware reset
// R18 - bit 2 gates own bus mastering
// R19 - host sets master enable before use
// R20 - bit 1 gates memory-space response
// R21 - only hardware reset restores defaults
// R22 - reserved bits read zero, ignore writes
`include "pcs_consts.svh"

module pcs_cmd_status
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // configuration access port
  input wire logic cfg_sel,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] bus_byte_enables_n,
  output logic [31:0] cfg_rdata_q,
  output logic cfg_done_q,
  output logic cfg_abort_q,
  // memory-space access from the bus target
  input wire logic mem_sel,
  input wire logic mem_wr,
  input wire logic [3:0] mem_byte_enables_n,
  output logic mem_claim_q,
  output logic mem_abort_q,
  // bus master request
  input wire logic mst_req,
  output logic mst_grant_q,
  // bus events
  input wire logic addr_par_err,
  input wire logic data_par_err,
  input wire logic perr_as_master,
  input wire logic mst_master_abort,
  input wire logic mst_target_abort,
  // capability bit from serial configuration memory
  input wire logic cap_load,
  input wire logic cap_present,
  // command controls and error signalling
  output logic mem_space_en_q,
  output logic bus_master_en_q,
  output logic parity_resp_en_q,
  output logic serr_en_q,
  output logic serr_assert_q,
  output logic fatal_err_q
);

  ////////////////////////////////////////////////////////////////////////
  // state
  pcs_state_t st_q;
  pcs_state_t st_d;

  logic [3:0] cfg_be;
  logic [3:0] mem_be;
  logic cfg_be_ok;
  logic mem_be_ok;
  logic hit;
  logic wr_ok;
  logic wr_bad;
  logic mem_go;
  logic mem_bad;
  logic serr_now;
  logic [31:0] wmask;
  logic [`PCS_N_STICKY-1:0] sticky_set;
  logic [`PCS_N_STICKY-1:0] sticky_clr;
  logic [`PCS_N_STICKY-1:0] sticky_q;
  logic [31:0] rd_word;
  // decoded accesses and event pulses
  logic cfg_rd_hit;
  logic cfg_wr_hit;
  logic lane0_wr;
  logic lane1_wr;
  logic par_any;
  logic tabt_cfg;
  logic tabt_mem;
  logic perr_det_ev;
  logic serr_sig_ev;
  logic mabt_ev;
  logic tabt_rcv_ev;
  logic tabt_sig_ev;
  logic dpr_ev;
  logic mem_ok;
  logic grant_now;
  logic fatal_now;

  ////////////////////////////////////////////////////////////////////////
  // byte-enable check

  function automatic logic be_legal(input logic [3:0] be);
    logic ok;
    ok = 1'h0;
    case (be)
      `PCS_BE_B0: ok = 1'h1;
      `PCS_BE_B1: ok = 1'h1;
      `PCS_BE_B2: ok = 1'h1;
      `PCS_BE_B3: ok = 1'h1;
      `PCS_BE_W0: ok = 1'h1;
      `PCS_BE_W1: ok = 1'h1;
      `PCS_BE_DW: ok = 1'h1;
      default: ok = 1'h0;
    endcase
    return ok;
  endfunction

  assign cfg_be = ~bus_byte_enables_n;
  assign mem_be = ~mem_byte_enables_n;
  assign cfg_be_ok = be_legal(cfg_be);
  assign mem_be_ok = be_legal(mem_be);

  // reads take any pattern, other cycles only legal ones
  assign wr_ok = cfg_sel && cfg_wr && cfg_be_ok; // [R10]
  assign wr_bad = cfg_sel && cfg_wr && !cfg_be_ok; // [R10]
  assign hit = (cfg_addr == `PCS_OFF_CMD_STAT);

  // decoded accesses to this register
  assign cfg_rd_hit = cfg_sel && !cfg_wr && hit; // [R3]
  assign cfg_wr_hit = wr_ok && hit; // [R10]
  assign lane0_wr = cfg_wr_hit && cfg_be[0]; // [R9]
  assign lane1_wr = cfg_wr_hit && cfg_be[1]; // [R9]

  // memory space only while its control is on
  assign mem_go = mem_sel && st_q.mem_en; // [R20] [R2]
  assign mem_bad = mem_go && mem_wr && !mem_be_ok; // [R10]

  // byte lane k covers bits 8k+7:8k
  assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                  {8{cfg_be[1]}}, {8{cfg_be[0]}}}; // [R9]

  ////////////////////////////////////////////////////////////////////////
  // status event sources

  assign serr_now = addr_par_err && st_q.serr_en; // [R15]
  assign par_any = addr_par_err || data_par_err;

  // target aborts we signal, as target of either space
  assign tabt_cfg = wr_bad; // [R10]
  assign tabt_mem = mem_bad; // [R10]

  // one set pulse per status flag
  assign perr_det_ev = par_any; // [R4]
  assign serr_sig_ev = serr_now; // [R5]
  assign mabt_ev = mst_master_abort; // [R6]
  assign tabt_rcv_ev = mst_target_abort; // [R7]
  assign tabt_sig_ev = tabt_cfg || tabt_mem; // [R8]
  assign dpr_ev = perr_as_master && st_q.per_en; // [R12]

  always_comb begin
    sticky_set = '0;
    sticky_set[`PCS_S_PERR_DET] = perr_det_ev;
    sticky_set[`PCS_S_SERR_SIG] = serr_sig_ev;
    sticky_set[`PCS_S_MABT_RCV] = mabt_ev;
    sticky_set[`PCS_S_TABT_RCV] = tabt_rcv_ev;
    sticky_set[`PCS_S_TABT_SIG] = tabt_sig_ev;
    sticky_set[`PCS_S_DPR] = dpr_ev;
  end

  // write one clears, write zero and reads leave alone
  always_comb begin
    logic [31:0] c;
    c = '0;
    if (cfg_wr_hit) begin
      c = cfg_wdata & wmask;
    end
    sticky_clr = '0;
    sticky_clr[`PCS_S_PERR_DET] = c[`PCS_B_PERR_DET]; // [R3]
    sticky_clr[`PCS_S_SERR_SIG] = c[`PCS_B_SERR_SIG]; // [R3]
    sticky_clr[`PCS_S_MABT_RCV] = c[`PCS_B_MABT_RCV]; // [R3]
    sticky_clr[`PCS_S_TABT_RCV] = c[`PCS_B_TABT_RCV]; // [R3]
    sticky_clr[`PCS_S_TABT_SIG] = c[`PCS_B_TABT_SIG]; // [R3]
    sticky_clr[`PCS_S_DPR] = c[`PCS_B_DPR]; // [R3]
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PCS_N_STICKY; gi++) begin : g_sticky
      pcs_sticky_bit u_bit (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .set(sticky_set[gi]),
        .clr(sticky_clr[gi]),
        .flag_q(sticky_q[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read image: command low half, status high half

  always_comb begin
    rd_word = `PCS_DATA_ZERO; // [R22]
    // command half
    rd_word[`PCS_B_MEM_EN] = st_q.mem_en; // [R1]
    rd_word[`PCS_B_MST_EN] = st_q.mst_en;
    rd_word[`PCS_B_PER_EN] = st_q.per_en;
    rd_word[`PCS_B_SERR_EN] = st_q.serr_en;
    // status half
    rd_word[`PCS_B_CAP] = st_q.cap; // [R14]
    rd_word[`PCS_B_66MHZ] = `PCS_66MHZ_CAP; // [R13]
    rd_word[`PCS_B_DPR] = sticky_q[`PCS_S_DPR];
    rd_word[`PCS_B_DSEL_HI:`PCS_B_DSEL_LO] = `PCS_DSEL_MEDIUM; // [R11]
    rd_word[`PCS_B_TABT_SIG] = sticky_q[`PCS_S_TABT_SIG];
    rd_word[`PCS_B_TABT_RCV] = sticky_q[`PCS_S_TABT_RCV];
    rd_word[`PCS_B_MABT_RCV] = sticky_q[`PCS_S_MABT_RCV];
    rd_word[`PCS_B_SERR_SIG] = sticky_q[`PCS_S_SERR_SIG];
    rd_word[`PCS_B_PERR_DET] = sticky_q[`PCS_S_PERR_DET];
  end

  ////////////////////////////////////////////////////////////////////////
  // gating of target, master and error paths

  assign mem_ok = mem_go && !mem_bad; // [R20]
  assign grant_now = mst_req && st_q.mst_en; // [R18]
  assign fatal_now = par_any && st_q.per_en; // [R16]

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    // one-cycle answers of the configuration port
    st_d.done = cfg_sel;
    st_d.abort = wr_bad; // [R10]
    st_d.rdata = `PCS_DATA_ZERO;
    // other configuration offsets read zero here
    if (cfg_rd_hit) begin
      st_d.rdata = rd_word; // [R3]
    end

    // command bits, lane by lane; reserved bits have no storage
    if (lane0_wr) begin
      st_d.mem_en = cfg_wdata[`PCS_B_MEM_EN]; // [R20]
      st_d.mst_en = cfg_wdata[`PCS_B_MST_EN]; // [R18]
      st_d.per_en = cfg_wdata[`PCS_B_PER_EN]; // [R16]
    end
    if (lane1_wr) begin
      st_d.serr_en = cfg_wdata[`PCS_B_SERR_EN]; // [R15]
    end

    if (cap_load) begin
      st_d.cap = cap_present; // [R14]
    end

    // bus target and bus master gating
    st_d.mem_claim = mem_ok; // [R20]
    st_d.mem_abort = mem_bad; // [R8]
    st_d.mst_grant = grant_now; // [R18]

    // error signalling
    st_d.serr_assert = serr_now; // [R15] [R5]
    st_d.fatal_err = fatal_now; // [R16]
  end

  ////////////////////////////////////////////////////////////////////////
  // registers; only the hardware reset pin restores defaults

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0; // [R17] [R21]
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // configuration answer
  assign cfg_rdata_q = st_q.rdata;
  assign cfg_done_q = st_q.done;
  assign cfg_abort_q = st_q.abort;
  // target and master gating
  assign mem_claim_q = st_q.mem_claim;
  assign mem_abort_q = st_q.mem_abort;
  assign mst_grant_q = st_q.mst_grant;
  // command levels and error signalling
  assign mem_space_en_q = st_q.mem_en;
  assign bus_master_en_q = st_q.mst_en;
  assign parity_resp_en_q = st_q.per_en;
  assign serr_en_q = st_q.serr_en;
  assign serr_assert_q = st_q.serr_assert;
  assign fatal_err_q = st_q.fatal_err;

endmodule

// ==== src/pcs_consts.svh ====
// named offsets, bit positions, patterns and fixed field values
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// register offset, byte address on the configuration port
`define PCS_OFF_CMD_STAT 8'h04

// command half, bits 15:0
`define PCS_B_MEM_EN 1
`define PCS_B_MST_EN 2
`define PCS_B_PER_EN 6
`define PCS_B_SERR_EN 8

// status half, bits 31:16
`define PCS_B_CAP 20
`define PCS_B_66MHZ 21
`define PCS_B_DPR 24
`define PCS_B_DSEL_LO 25
`define PCS_B_DSEL_HI 26
`define PCS_B_TABT_SIG 27
`define PCS_B_TABT_RCV 28
`define PCS_B_MABT_RCV 29
`define PCS_B_SERR_SIG 30
`define PCS_B_PERR_DET 31

// sticky status bits, index into the sticky vector
`define PCS_N_STICKY 6
`define PCS_S_DPR 0
`define PCS_S_TABT_SIG 1
`define PCS_S_TABT_RCV 2
`define PCS_S_MABT_RCV 3
`define PCS_S_SERR_SIG 4
`define PCS_S_PERR_DET 5

// fixed fields
`define PCS_DSEL_MEDIUM 2'h1
`define PCS_66MHZ_CAP 1'h0
`define PCS_DATA_ZERO 32'h0000_0000

// legal write byte-enable patterns, active high
`define PCS_BE_B0 4'h1
`define PCS_BE_B1 4'h2
`define PCS_BE_B2 4'h4
`define PCS_BE_B3 4'h8
`define PCS_BE_W0 4'h3
`define PCS_BE_W1 4'hc
`define PCS_BE_DW 4'hf

`endif

// ==== src/pcs_pkg.sv ====
// types of the command and status register block
package pcs_pkg;

  typedef struct packed {
    logic flag;
  } pcs_sticky_t;

  typedef struct packed {
    logic mem_en;
    logic mst_en;
    logic per_en;
    logic serr_en;
    logic cap;
    logic [31:0] rdata;
    logic done;
    logic abort;
    logic mem_claim;
    logic mem_abort;
    logic mst_grant;
    logic serr_assert;
    logic fatal_err;
  } pcs_state_t;

endpackage

// ==== src/pcs_sticky_bit.sv ====
// one status flag set by hardware, cleared by writing one
module pcs_sticky_bit
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // set and clear
  input wire logic set,
  input wire logic clr,
  // flag
  output logic flag_q
);

  pcs_sticky_t st_q;
  pcs_sticky_t st_d;

  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.flag = 1'h0;
    end
    // set wins over a clear in the same cycle
    if (set) begin
      st_d.flag = 1'h1; // [R3]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_q = st_q.flag;

endmodule
